// ==== rtl/kgs_click_gen.sv ====
// Keyclick square-wave generator with programmable octave and length.
// Assumes run_req is held until done_q is seen and then dropped.
`timescale 1ns/10ps
`default_nettype none
module kgs_click_gen
   import kgs_pkg::*;
#(
   parameter int unsigned HALF_CYC = CLICK_BASE_HALF_CYC
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Control
   input  wire logic       run_req,
   input  wire logic [2:0] freq_sel,
   input  wire logic [3:0] len_sel,
   // Tone
   output logic            wave_q,
   output logic            busy_q,
   output logic            done_q
);
   kgs_click_e       st_q,   st_d;
   logic [CNT_W-1:0] cnt_q,  cnt_d;
   logic [5:0]       half_q, half_d;
   logic             wave_d, busy_d, done_d;
   logic [CNT_W-1:0] halfc,  lim;
   logic [5:0]       last_half;

   assign halfc = CNT_W'(HALF_CYC >> freq_sel);
   assign lim   = (halfc > CNT_W'(1)) ? halfc - CNT_W'(1) : '0;
   assign last_half = {len_sel, 2'b11};

   always_comb
   begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      half_d = half_q;
      wave_d = wave_q;
      done_d = 1'b0;
      case (st_q)
         KGS_IDLE:
         begin
            if (run_req && !done_q)
            begin
               st_d   = KGS_RUN;
               cnt_d  = '0;
               half_d = '0;
               wave_d = 1'b1;
            end
         end
         KGS_RUN:
         begin
            if (!run_req)
            begin
               st_d   = KGS_IDLE;
               wave_d = 1'b0;
            end
            else if (cnt_q >= lim)
            begin
               cnt_d = '0;
               if (half_q == last_half)
               begin
                  st_d   = KGS_IDLE;
                  wave_d = 1'b0;
                  done_d = 1'b1;
               end
               else
               begin
                  half_d = half_q + 6'h01;
                  wave_d = ~wave_q;
               end
            end
            else
            begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         default:
         begin
            st_d   = KGS_IDLE;
            wave_d = 1'b0;
         end
      endcase
      busy_d = (st_d == KGS_RUN);
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         st_q   <= KGS_IDLE;
         cnt_q  <= '0;
         half_q <= '0;
         wave_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         half_q <= half_d;
         wave_q <= wave_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   property p_toggle;
      @(posedge clk) disable iff (!reset_n)
      (st_q == KGS_RUN) && run_req && (cnt_q >= lim) && (half_q != last_half)
         |=> wave_q != $past(wave_q);
   endproperty
   a_toggle: assert property (p_toggle) else $error("tone did not toggle");

   property p_length;
      @(posedge clk) disable iff (!reset_n)
      done_q |-> ($past(half_q) == {$past(len_sel), 2'b11}) && !busy_q;
   endproperty
   a_length: assert property (p_length) else $error("tone length wrong");
endmodule : kgs_click_gen
`default_nettype wire

// ==== rtl/kgs_gain_step.sv ====
// One soft-stepping gain channel: walks the applied code toward the target.
// Assumes fsync is a one-cycle pulse and the target is stable between frames.
`timescale 1ns/10ps
`default_nettype none
module kgs_gain_step
   import kgs_pkg::*;
#(
   parameter logic [6:0] RST_GAIN = DAC_GAIN_RST
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Stepper bundle
   kgs_step_if.stepper sp
);
   logic       half_q,    half_d;
   logic [6:0] applied_q, applied_d;
   logic       settled_q, settled_d;

   always_comb
   begin
      half_d    = sp.fsync ? ~half_q : half_q;
      applied_d = applied_q;
      settled_d = (applied_q == sp.target);
      if (sp.fsync && (!sp.rate || half_q))
      begin
         applied_d = kgs_step_toward(applied_q, sp.target);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         half_q    <= 1'b0;
         applied_q <= RST_GAIN;
         settled_q <= 1'b0;
      end
      else
      begin
         half_q    <= half_d;
         applied_q <= applied_d;
         settled_q <= settled_d;
      end
   end

   assign sp.applied = applied_q;
   assign sp.settled = settled_q;

   property p_step_fast;
      @(posedge clk) disable iff (!reset_n)
      sp.fsync && !sp.rate && (applied_q != sp.target) |=> applied_q != $past(applied_q);
   endproperty
   a_step_fast: assert property (p_step_fast) else $error("gain missed a step");

   property p_step_slow;
      @(posedge clk) disable iff (!reset_n)
      sp.fsync && sp.rate && !half_q |=> applied_q == $past(applied_q);
   endproperty
   a_step_slow: assert property (p_step_slow) else $error("gain stepped too fast");

   property p_unit_step;
      @(posedge clk) disable iff (!reset_n)
      ##1 (applied_q != $past(applied_q)) |->
         (applied_q == $past(applied_q) + 7'h01) || (applied_q == $past(applied_q) - 7'h01);
   endproperty
   a_unit_step: assert property (p_unit_step) else $error("gain moved too far");
endmodule : kgs_gain_step
`default_nettype wire

// ==== rtl/kgs_keyclick_gain_ctrl.sv ====
// Keyclick and gain step control register with its tone and stepper logic.
// Assumes a decoded host word port and one-cycle frame sync pulses on clk.
`timescale 1ns/10ps
`default_nettype none
module kgs_keyclick_gain_ctrl
   import kgs_pkg::*;
#(
   parameter int unsigned CLICK_HALF_CYC = CLICK_BASE_HALF_CYC
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Host register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata_q,
   // Audio frame syncs
   input  wire logic        dac_frame_sync,
   input  wire logic        adc_frame_sync,
   // Programmed gain targets
   input  wire logic [6:0]  left_dac_volume,
   input  wire logic [6:0]  right_dac_volume,
   input  wire logic [6:0]  analog_gain_target,
   // Automatic gain control status
   input  wire logic        agc_active,
   input  wire logic        agc_noise_below,
   // Applied gains
   output logic      [6:0]  left_dac_gain,
   output logic      [6:0]  right_dac_gain,
   output logic      [6:0]  analog_gain,
   // Keyclick tone
   output logic             click_wave,
   output logic             click_active,
   output logic      [2:0]  click_level
);
   logic        wr_hit, rd_hit;
   logic        click_trigger_q,         click_trigger_d;
   logic [2:0]  click_amplitude_sel_q,   click_amplitude_sel_d;
   logic        analog_gain_step_rate_q, analog_gain_step_rate_d;
   logic [2:0]  click_tone_freq_q,       click_tone_freq_d;
   logic [3:0]  click_length_sel_q,      click_length_sel_d;
   logic        dac_gain_step_rate_q,    dac_gain_step_rate_d;
   logic [15:0] reg_rdata_d;
   logic        click_done;
   logic        agc_saturated;
   logic        rate_flag, analog_flag;
   logic        left_dac_gain_settled;
   logic        right_dac_gain_settled;
   logic        analog_gain_settled;

   kgs_step_if step_left ();
   kgs_step_if step_right ();
   kgs_step_if step_analog ();

   assign wr_hit = reg_wr && (reg_addr == KGS_REG_OFS);
   assign rd_hit = reg_rd && (reg_addr == KGS_REG_OFS);

   assign agc_saturated = (analog_gain == PGA_SAT_LOW) || (analog_gain == PGA_SAT_HIGH);
   assign rate_flag = agc_active ? agc_noise_below : analog_gain_step_rate_q;
   assign analog_flag = agc_active ? agc_saturated : analog_gain_settled;

   always_comb
   begin
      click_trigger_d         = click_trigger_q;
      click_amplitude_sel_d   = click_amplitude_sel_q;
      analog_gain_step_rate_d = analog_gain_step_rate_q;
      click_tone_freq_d       = click_tone_freq_q;
      click_length_sel_d      = click_length_sel_q;
      dac_gain_step_rate_d    = dac_gain_step_rate_q;
      if (wr_hit)
      begin
         click_trigger_d = reg_wdata[TRIG_BIT];
      end
      else if (click_done)
      begin
         click_trigger_d = 1'b0;
      end
      if (wr_hit)
      begin
         click_amplitude_sel_d = reg_wdata[AMP_LSB +: 3];
         click_tone_freq_d     = reg_wdata[FREQ_LSB +: 3];
         click_length_sel_d    = reg_wdata[LEN_LSB +: 4];
         dac_gain_step_rate_d  = reg_wdata[RATE_D_BIT];
         if (!agc_active)
         begin
            analog_gain_step_rate_d = reg_wdata[RATE_A_BIT];
         end
      end
   end

   always_comb
   begin
      reg_rdata_d = 16'h0000;
      if (rd_hit)
      begin
         reg_rdata_d = {click_trigger_q, click_amplitude_sel_q, rate_flag,
                        click_tone_freq_q, click_length_sel_q,
                        left_dac_gain_settled, right_dac_gain_settled,
                        dac_gain_step_rate_q, analog_flag};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         click_trigger_q         <= 1'b0;
         click_amplitude_sel_q   <= AMP_RST;
         analog_gain_step_rate_q <= 1'b0;
         click_tone_freq_q       <= FREQ_RST;
         click_length_sel_q      <= LEN_RST;
         dac_gain_step_rate_q    <= 1'b0;
         reg_rdata_q             <= 16'h0000;
      end
      else
      begin
         click_trigger_q         <= click_trigger_d;
         click_amplitude_sel_q   <= click_amplitude_sel_d;
         analog_gain_step_rate_q <= analog_gain_step_rate_d;
         click_tone_freq_q       <= click_tone_freq_d;
         click_length_sel_q      <= click_length_sel_d;
         dac_gain_step_rate_q    <= dac_gain_step_rate_d;
         reg_rdata_q             <= reg_rdata_d;
      end
   end

   assign click_level = click_amplitude_sel_q;

   assign step_left.fsync   = dac_frame_sync;
   assign step_left.rate    = dac_gain_step_rate_q;
   assign step_left.target  = left_dac_volume;
   assign step_right.fsync  = dac_frame_sync;
   assign step_right.rate   = dac_gain_step_rate_q;
   assign step_right.target = right_dac_volume;
   assign step_analog.fsync  = adc_frame_sync;
   assign step_analog.rate   = analog_gain_step_rate_q;
   assign step_analog.target = analog_gain_target;

   assign left_dac_gain          = step_left.applied;
   assign right_dac_gain         = step_right.applied;
   assign analog_gain            = step_analog.applied;
   assign left_dac_gain_settled  = step_left.settled;
   assign right_dac_gain_settled = step_right.settled;
   assign analog_gain_settled    = step_analog.settled;

   kgs_gain_step #(
      .RST_GAIN (DAC_GAIN_RST)
   ) u_step_left (
      .clk     (clk),
      .reset_n (reset_n),
      .sp      (step_left.stepper)
   );

   kgs_gain_step #(
      .RST_GAIN (DAC_GAIN_RST)
   ) u_step_right (
      .clk     (clk),
      .reset_n (reset_n),
      .sp      (step_right.stepper)
   );

   kgs_gain_step #(
      .RST_GAIN (PGA_GAIN_RST)
   ) u_step_analog (
      .clk     (clk),
      .reset_n (reset_n),
      .sp      (step_analog.stepper)
   );

   kgs_click_gen #(
      .HALF_CYC (CLICK_HALF_CYC)
   ) u_click (
      .clk      (clk),
      .reset_n  (reset_n),
      .run_req  (click_trigger_q),
      .freq_sel (click_tone_freq_q),
      .len_sel  (click_length_sel_q),
      .wave_q   (click_wave),
      .busy_q   (click_active),
      .done_q   (click_done)
   );

   property p_autoclear;
      @(posedge clk) disable iff (!reset_n)
      click_done && !wr_hit |=> !click_trigger_q;
   endproperty
   a_autoclear: assert property (p_autoclear) else $error("enable not cleared");

   property p_start;
      @(posedge clk) disable iff (!reset_n)
      wr_hit && reg_wdata[TRIG_BIT] && !click_active |=> ##[1:2] click_active;
   endproperty
   a_start: assert property (p_start) else $error("tone did not start");

   property p_amp;
      @(posedge clk) disable iff (!reset_n)
      wr_hit |=> click_level == $past(reg_wdata[14:12]);
   endproperty
   a_amp: assert property (p_amp) else $error("amplitude not applied");

   property p_noise;
      @(posedge clk) disable iff (!reset_n)
      rd_hit && agc_active |=> reg_rdata_q[RATE_A_BIT] == $past(agc_noise_below);
   endproperty
   a_noise: assert property (p_noise) else $error("noise flag wrong");

   property p_rate_hold;
      @(posedge clk) disable iff (!reset_n)
      wr_hit && agc_active |=> analog_gain_step_rate_q == $past(analog_gain_step_rate_q);
   endproperty
   a_rate_hold: assert property (p_rate_hold) else $error("rate written under AGC");

   property p_left;
      @(posedge clk) disable iff (!reset_n)
      rd_hit ##1 (left_dac_gain == left_dac_volume) [*2] |->
         ##1 step_left.settled;
   endproperty
   a_left: assert property (p_left) else $error("left flag not set");

   property p_right;
      @(posedge clk) disable iff (!reset_n)
      rd_hit |=> reg_rdata_q[RFLAG_BIT] == $past(right_dac_gain_settled);
   endproperty
   a_right: assert property (p_right) else $error("right flag wrong");

   property p_analog;
      @(posedge clk) disable iff (!reset_n)
      rd_hit && !agc_active |=> reg_rdata_q[AFLAG_BIT] == $past(analog_gain_settled);
   endproperty
   a_analog: assert property (p_analog) else $error("analog flag wrong");

   property p_sat;
      @(posedge clk) disable iff (!reset_n)
      rd_hit && agc_active && (analog_gain == PGA_SAT_LOW) |=> reg_rdata_q[AFLAG_BIT];
   endproperty
   a_sat: assert property (p_sat) else $error("saturation flag wrong");

   property p_ro_flags;
      @(posedge clk) disable iff (!reset_n)
      wr_hit |=>
         (left_dac_gain_settled == $past(left_dac_gain == left_dac_volume)) &&
         (right_dac_gain_settled == $past(right_dac_gain == right_dac_volume));
   endproperty
   a_ro_flags: assert property (p_ro_flags) else $error("write disturbed a flag");
endmodule : kgs_keyclick_gain_ctrl
`default_nettype wire

// ==== shared/kgs_pkg.sv ====
// Constants, types and helpers for the keyclick and gain step control block.
// Assumes a single 125 MHz clock and a host word port that is already decoded.
// Functional notes
// - Setting the click enable plays the tone, then hardware clears the bit.
// - Three-bit amplitude field picks tone level, 000 lowest, 100 medium, 111 highest.
// - Three-bit frequency field picks octaves from 62.5 Hz (000) to 8 kHz (111).
// - Four-bit length field gives 2 to 32 tone periods in steps of two.
// - Analog gain steps 0.5 dB each frame sync, or every second when set.
// - With AGC active, bit 11 is read-only and reports the noise threshold flag.
// - Left DAC flag reads 1 when applied gain equals programmed gain, else 0.
// - Right DAC flag reads 1 when applied gain equals programmed gain, else 0.
// - DAC gain steps 0.5 dB each frame sync, or every second when set.
// - Analog gain flag reads 1 when applied gain equals programmed gain, else 0.
// - With AGC active, bit 0 reports saturation at -12 dB or maximum gain.
// - DAC volume codes attenuate 0.5 dB per step, 0 dB to -63.5 dB.
`default_nettype none
package kgs_pkg;
   localparam int unsigned CLK_FREQ_HZ          = 125_000_000;
   // Period of the lowest click tone, 62.5 Hz, in microseconds.
   localparam int unsigned CLICK_BASE_PERIOD_US = 16_000;
   localparam int unsigned CLICK_BASE_HALF_CYC  =
      CLK_FREQ_HZ / 1_000_000 * CLICK_BASE_PERIOD_US / 2;
   localparam int unsigned CNT_W                = 24;
   localparam logic [7:0]  KGS_REG_OFS          = 8'h04;
   localparam int unsigned TRIG_BIT             = 15;
   localparam int unsigned AMP_LSB              = 12;
   localparam int unsigned RATE_A_BIT           = 11;
   localparam int unsigned FREQ_LSB             = 8;
   localparam int unsigned LEN_LSB              = 4;
   localparam int unsigned LFLAG_BIT            = 3;
   localparam int unsigned RFLAG_BIT            = 2;
   localparam int unsigned RATE_D_BIT           = 1;
   localparam int unsigned AFLAG_BIT            = 0;
   localparam logic [2:0]  AMP_RST              = 3'h4;
   localparam logic [2:0]  FREQ_RST             = 3'h4;
   localparam logic [3:0]  LEN_RST              = 4'h1;
   localparam logic [6:0]  DAC_GAIN_RST         = 7'h7F;
   localparam logic [6:0]  PGA_GAIN_RST         = 7'h00;
   localparam logic [6:0]  PGA_SAT_LOW          = 7'h00;
   localparam logic [6:0]  PGA_SAT_HIGH         = 7'h77;

   typedef enum logic [1:0] {
      KGS_IDLE = 2'b01,
      KGS_RUN  = 2'b10
   } kgs_click_e;

   function automatic logic [6:0] kgs_step_toward(input logic [6:0] cur,
                                                  input logic [6:0] tgt);
      if (cur < tgt)
      begin
         return cur + 7'h01;
      end
      else if (cur > tgt)
      begin
         return cur - 7'h01;
      end
      return cur;
   endfunction : kgs_step_toward
endpackage : kgs_pkg
`default_nettype wire

// ==== shared/kgs_step_if.sv ====
// Bundle between the control logic and one gain stepper.
// Assumes the frame sync is a one-cycle pulse in the clk domain.
`timescale 1ns/10ps
`default_nettype none
interface kgs_step_if;
   logic       fsync;
   logic       rate;
   logic [6:0] target;
   logic [6:0] applied;
   logic       settled;
   modport stepper (input fsync, input rate, input target,
                    output applied, output settled);
   modport ctrl (output fsync, output rate, output target,
                 input applied, input settled);
endinterface : kgs_step_if
`default_nettype wire

// ==== testbench/kgs_host_model.sv ====
// Host model that drives the register port of the keyclick and gain step block.
// Assumes the bench calls its tasks from one process and that clk is running.
`timescale 1ns/10ps
`default_nettype none
module kgs_host_model
(
   // Clock
   input  wire logic        clk,
   // Register port
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [7:0]  reg_addr,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata_q
);
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
   end

   // Strobes last one sampling edge; released lines show inverted values.
   task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
      @(negedge clk);
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_addr  = ~addr;
      reg_wdata = ~data;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
      @(negedge clk);
      reg_rd   = 1'b1;
      reg_addr = addr;
      @(negedge clk);
      reg_rd   = 1'b0;
      reg_addr = ~addr;
      data     = reg_rdata_q;
   endtask : read_reg
endmodule : kgs_host_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the keyclick and gain step control register.
// Assumes kgs_pkg, the interface and the design sources are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import kgs_pkg::*;
   localparam int unsigned HALF    = 8;
   localparam int unsigned MAX_CYC = 30000;
   logic        clk;
   logic        reset_n;
   wire logic   reg_wr;
   wire logic   reg_rd;
   wire logic [7:0]  reg_addr;
   wire logic [15:0] reg_wdata;
   logic [15:0] reg_rdata_q;
   logic        dac_frame_sync;
   logic        adc_frame_sync;
   logic [6:0]  left_dac_volume;
   logic [6:0]  right_dac_volume;
   logic [6:0]  analog_gain_target;
   logic        agc_active;
   logic        agc_noise_below;
   logic [6:0]  left_dac_gain;
   logic [6:0]  right_dac_gain;
   logic [6:0]  analog_gain;
   logic        click_wave;
   logic        click_active;
   logic [2:0]  click_level;
   logic [6:0]  ml;
   logic [6:0]  mr;
   logic [6:0]  ma;
   logic [15:0] ctl;
   logic [15:0] seed;
   logic [3:0]  len;
   int          error_cnt;
   int          checked;
   int          cyc_cnt;
   int          cnt;
   int          hi;

   kgs_keyclick_gain_ctrl #(.CLICK_HALF_CYC(HALF)) i_dut (.clk(clk), .reset_n(reset_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .dac_frame_sync(dac_frame_sync),
      .adc_frame_sync(adc_frame_sync), .left_dac_volume(left_dac_volume),
      .right_dac_volume(right_dac_volume), .analog_gain_target(analog_gain_target),
      .agc_active(agc_active), .agc_noise_below(agc_noise_below),
      .left_dac_gain(left_dac_gain), .right_dac_gain(right_dac_gain),
      .analog_gain(analog_gain), .click_wave(click_wave), .click_active(click_active),
      .click_level(click_level));
   kgs_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

   always #4 clk = ~clk;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic logic [6:0] toward(input logic [6:0] c, input logic [6:0] t);
      return (c == t) ? c : ((c < t) ? c + 7'h01 : c - 7'h01);
   endfunction : toward

   // Expected register image from the written bits and the gain models.
   function automatic logic [23:0] exp_reg();
      logic [15:0] v;
      v = ctl & 16'hFFF2;
      if (agc_active)
         v[11] = agc_noise_below;
      v[3] = (ml == left_dac_volume);
      v[2] = (mr == right_dac_volume);
      v[0] = agc_active ? (ma == 7'h00 || ma == 7'h77) : (ma == analog_gain_target);
      return {8'h00, v};
   endfunction : exp_reg

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checked = checked + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic check_reg(input logic [7:0] addr);
      logic [15:0] rd;
      i_host.read_reg(addr, rd);
      check("register", (addr == 8'h04) ? exp_reg() : 24'h0, {8'h00, rd});
   endtask : check_reg

   task automatic wr(input logic [15:0] data);
      i_host.write_reg(8'h04, data);
      ctl = agc_active ? {data[15:12], ctl[11], data[10:0]} : data;
   endtask : wr

   task automatic pulse(input logic dac, input logic adc, input logic track);
      @(negedge clk);
      dac_frame_sync = dac;
      adc_frame_sync = adc;
      @(negedge clk);
      dac_frame_sync = 1'b0;
      adc_frame_sync = 1'b0;
      if (track)
      begin
         ml = dac ? toward(ml, left_dac_volume) : ml;
         mr = dac ? toward(mr, right_dac_volume) : mr;
         ma = adc ? toward(ma, analog_gain_target) : ma;
         check("gains", {3'h0, ml, mr, ma}, {3'h0, left_dac_gain, right_dac_gain, analog_gain});
      end
   endtask : pulse

   always @(posedge clk)
   begin
      cyc_cnt = cyc_cnt + 1;
      if (cyc_cnt == MAX_CYC)
      begin
         error_cnt = error_cnt + 1;
         end_of_test();
      end
   end

   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      dac_frame_sync = 1'b0;
      adc_frame_sync = 1'b0;
      left_dac_volume = 7'h7F;
      right_dac_volume = 7'h7F;
      analog_gain_target = 7'h00;
      agc_active = 1'b0;
      agc_noise_below = 1'b0;
      ml = 7'h7F;
      mr = 7'h7F;
      ma = 7'h00;
      ctl = 16'h4410;
      seed = 16'h0016;
      error_cnt = 0;
      checked = 0;
      cyc_cnt = 0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      repeat (3) @(negedge clk);
      check_reg(8'h04);
      wr(16'h0000);
      check_reg(8'h04);
      i_host.write_reg(8'h05, 16'hFFFF);
      check_reg(8'h05);
      check_reg(8'h04);
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         left_dac_volume = seed[6:0];
         seed = lfsr(seed);
         right_dac_volume = seed[13:7];
         analog_gain_target = seed[6:0];
         for (int i = 0; i < 300; i++)
         begin
            seed = lfsr(seed);
            pulse(seed[0], seed[1], 1'b1);
         end
         repeat (3) @(negedge clk);
         check_reg(8'h04);
      end
      wr(16'h0802);
      left_dac_volume = (ml < 7'h40) ? 7'h7F : 7'h00;
      right_dac_volume = (mr < 7'h40) ? 7'h7F : 7'h00;
      analog_gain_target = (ma < 7'h40) ? 7'h7F : 7'h00;
      repeat (4) pulse(1'b1, 1'b1, 1'b0);
      ml = toward(toward(ml, left_dac_volume), left_dac_volume);
      mr = toward(toward(mr, right_dac_volume), right_dac_volume);
      ma = toward(toward(ma, analog_gain_target), analog_gain_target);
      check("slow gains", {3'h0, ml, mr, ma}, {3'h0, left_dac_gain, right_dac_gain, analog_gain});
      check_reg(8'h04);
      wr(16'h0000);
      agc_active = 1'b1;
      agc_noise_below = 1'b1;
      repeat (3) @(negedge clk);
      check_reg(8'h04);
      wr(16'h0800);
      agc_noise_below = 1'b0;
      repeat (3) @(negedge clk);
      check_reg(8'h04);
      analog_gain_target = 7'h00;
      repeat (130) pulse(1'b0, 1'b1, 1'b1);
      repeat (3) @(negedge clk);
      check_reg(8'h04);
      agc_active = 1'b0;
      wr(16'h0000);
      for (int f = 0; f < 8; f++)
      begin
         len = (f == 7) ? 4'hF : 4'(2 * f);
         wr({1'b1, 3'(f), 1'b0, 3'(f), len, 4'h0});
         ctl[15] = 1'b0;
         cnt = 0;
         while (click_active !== 1'b1 && cnt < 8)
         begin
            cnt = cnt + 1;
            @(negedge clk);
         end
         check("level", {21'h0, 3'(f)}, {21'h0, click_level});
         cnt = 0;
         hi = 0;
         while (click_active === 1'b1 && cnt < 4000)
         begin
            cnt = cnt + 1;
            hi = hi + int'(click_wave === 1'b1);
            @(negedge clk);
         end
         check("length", 24'(4 * (len + 1) * ((HALF >> f) > 0 ? (HALF >> f) : 1)),
               24'(cnt));
         check("wave high", 24'(2 * (len + 1) * ((HALF >> f) > 0 ? (HALF >> f) : 1)),
               24'(hi));
         @(negedge clk);
         check_reg(8'h04);
      end
      wr(16'h80F0);
      repeat (20) @(negedge clk);
      wr(16'h00F0);
      repeat (2) @(negedge clk);
      check("abort", 24'h0, {23'h0, click_active});
      check_reg(8'h04);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
